// ==== rtl/ric_pkg.sv ====
// Constants and types shared by the reset and interrupt controller
package ric_pkg;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] ENABLE_OFS = 8'h04;
	localparam logic [7:0] LATCH_OFS = 8'h08;
	localparam logic [7:0] SELECT_OFS = 8'h0c;
	localparam logic [7:0] SYSCTL_OFS = 8'h10;
	localparam logic [7:0] STATUS_OFS = 8'h14;
	localparam logic [7:0] DIVIDER_OFS = 8'h18;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int CTRL_IMF = 0;
	localparam int CTRL_TRAP_SEL = 1;
	localparam int CTRL_WDT_SEL = 2;
	localparam int CTRL_RAM_TRAP = 3;
	localparam int CTRL_EXT0_PIN = 4;
	localparam int CTRL_WDT_EN = 5;
	localparam logic [5:0] CTRL_RESET = 6'h26;
	localparam int SYS_CLK_SEL = 0;
	localparam int SYS_HF_EN = 1;
	localparam int SYS_LF_EN = 2;
	localparam logic [2:0] SYS_RESET = 3'h2;
	localparam logic [15:0] ENABLE_MASK = 16'hfff0;
	localparam logic [15:0] LATCH_MASK = 16'hfffc;

	// ----------------------------------------
	// Timing counts in fc periods
	// ----------------------------------------
	localparam logic [4:0] MAL_RESET_CYCLES = 5'h18;
	localparam logic [3:0] PIN_MIN_CYCLES = 4'hc;

	// ----------------------------------------
	// Vectors and trap areas
	// ----------------------------------------
	localparam logic [15:0] VEC_BASE = 16'hfffe;
	localparam logic [3:0] ID_SOFT = 4'h1;
	localparam logic [3:0] ID_TRAP = 4'h2;
	localparam logic [3:0] ID_WDT = 4'h3;
	localparam logic [3:0] ID_EXT0 = 4'h4;
	localparam logic [15:0] SFR_LO = 16'h0000;
	localparam logic [15:0] SFR_HI = 16'h003f;
	localparam logic [15:0] RAM_LO = 16'h0040;
	localparam logic [15:0] RAM_HI = 16'h083f;
	localparam logic [15:0] DBR_LO = 16'h0f80;
	localparam logic [15:0] DBR_HI = 16'h0fff;
	localparam int STACK_DEPTH = 8;

	// Peripheral request inputs, one-cycle pulses
	typedef struct packed {
		logic external_irq_0;
		logic uart_receive_irq;
		logic external_irq_1;
		logic time_base_irq;
		logic timer3_irq;
		logic serial_io_irq;
		logic two_wire_irq;
		logic timer4_irq;
		logic external_irq_3;
		logic external_irq_4;
		logic uart_transmit_irq;
		logic timer2_irq;
		logic external_irq_5;
		logic converter_done_irq;
		logic external_irq_2;
	} ric_src_t;

	// Request presented to the core
	typedef struct packed {
		logic req;
		logic [3:0] id;
		logic [15:0] vector;
	} ric_irq_t;

endpackage : ric_pkg

// ==== rtl/ric_top.sv ====
// Reset generation and interrupt arbitration with an AHB-Lite register slave
//
// The AHB-Lite register port and the register addresses were decided locally.
module ric_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic rst_pin_n,
	input wire logic fetch_valid,
	input wire logic [15:0] fetch_addr,
	input wire logic watchdog_overflow,
	input wire logic software_trap_irq,
	input wire logic illegal_opcode_irq,
	input wire ric_pkg::ric_src_t sources,
	input wire logic irq_ack,
	input wire logic irq_return,
	output logic cpu_reset_n,
	output logic pc_load,
	output logic [15:0] reset_vector,
	output logic watchdog_enable,
	output ric_pkg::ric_irq_t irq
);

	// ----------------------------------------
	// Reset sources
	// ----------------------------------------
	logic [3:0] pin_cnt, next_pin_cnt;
	logic [4:0] mal_cnt, next_mal_cnt;
	logic [5:0] ctrl, next_ctrl;
	logic [15:0] ef, next_ef;
	logic [15:0] il, next_il;
	logic [2:0] sel, next_sel;
	logic [2:0] sys, next_sys;
	logic [3:0] cause, next_cause;
	logic [15:0] div, next_div;
	localparam int STACK_W = ric_pkg::STACK_DEPTH;
	logic [STACK_W-1:0] stack, next_stack;
	logic wr_pend, next_wr_pend;
	logic [7:0] wr_addr, next_wr_addr;
	logic [31:0] next_hrdata;
	logic next_cpu_reset_n, next_pc_load;
	ric_pkg::ric_irq_t next_irq;
	logic pin_rst, core_rst, mal_req;
	logic trap_hit, trap_rst, trap_irq, wdt_rst, wdt_irq, clk_rst;
	logic sys_wr;
	logic [2:0] wsys;
	logic [15:0] set_il, req_vec;
	logic addr_phase;

	// Pin filter and malfunction stretch
	assign pin_rst = (pin_cnt == ric_pkg::PIN_MIN_CYCLES);
	assign core_rst = pin_rst | (mal_cnt != 5'h0);
	assign mal_req = trap_rst | wdt_rst | clk_rst;

	// Trap detection on instruction fetch
	always_comb begin
		trap_hit = 1'b0;
		if (fetch_valid && !core_rst) begin
			if (fetch_addr <= ric_pkg::SFR_HI)
				trap_hit = 1'b1;
			if (fetch_addr >= ric_pkg::DBR_LO && fetch_addr <= ric_pkg::DBR_HI)
				trap_hit = 1'b1;
			if (ctrl[ric_pkg::CTRL_RAM_TRAP] && fetch_addr >= ric_pkg::RAM_LO
					&& fetch_addr <= ric_pkg::RAM_HI)
				trap_hit = 1'b1;
		end
	end

	assign trap_rst = trap_hit & ctrl[ric_pkg::CTRL_TRAP_SEL];
	assign trap_irq = trap_hit & ~ctrl[ric_pkg::CTRL_TRAP_SEL];
	assign wdt_rst = watchdog_overflow & ~core_rst & ctrl[ric_pkg::CTRL_WDT_SEL];
	assign wdt_irq = watchdog_overflow & ~core_rst & ~ctrl[ric_pkg::CTRL_WDT_SEL];

	// Bus write to the clock control register
	assign sys_wr = wr_pend && (wr_addr == ric_pkg::SYSCTL_OFS);
	assign wsys = hwdata[2:0];

	// Illegal oscillator stop detection
	always_comb begin
		clk_rst = 1'b0;
		if (sys_wr && !core_rst) begin
			if (sys[ric_pkg::SYS_HF_EN] && sys[ric_pkg::SYS_LF_EN]
					&& !wsys[ric_pkg::SYS_HF_EN] && !wsys[ric_pkg::SYS_LF_EN])
				clk_rst = 1'b1;
			if (!sys[ric_pkg::SYS_CLK_SEL] && sys[ric_pkg::SYS_HF_EN]
					&& !wsys[ric_pkg::SYS_HF_EN])
				clk_rst = 1'b1;
			if (sys[ric_pkg::SYS_CLK_SEL] && sys[ric_pkg::SYS_LF_EN]
					&& !wsys[ric_pkg::SYS_LF_EN])
				clk_rst = 1'b1;
		end
	end

	// Latch set requests, shared levels muxed by selector
	always_comb begin
		set_il = 16'h0;
		set_il[2] = trap_irq;
		set_il[3] = wdt_irq;
		set_il[4] = sources.external_irq_0;
		set_il[5] = sources.uart_receive_irq;
		set_il[6] = sources.external_irq_1;
		set_il[7] = sources.time_base_irq;
		set_il[8] = sources.timer3_irq;
		set_il[9] = sel[0] ? sources.two_wire_irq : sources.serial_io_irq;
		set_il[10] = sources.timer4_irq;
		set_il[11] = sources.external_irq_3;
		set_il[12] = sources.external_irq_4;
		set_il[13] = sources.uart_transmit_irq;
		set_il[14] = sel[1] ? sources.external_irq_5 : sources.timer2_irq;
		set_il[15] = sel[2] ? sources.external_irq_2 : sources.converter_done_irq;
	end

	// ----------------------------------------
	// Register and state next values
	// ----------------------------------------
	always_comb begin
		next_pin_cnt = pin_cnt;
		if (rst_pin_n)
			next_pin_cnt = 4'h0;
		else if (!pin_rst)
			next_pin_cnt = pin_cnt + 4'h1;
		next_mal_cnt = 5'h0;
		if (mal_req)
			next_mal_cnt = ric_pkg::MAL_RESET_CYCLES;
		else if (mal_cnt != 5'h0)
			next_mal_cnt = mal_cnt - 5'h1;
		next_ctrl = ctrl;
		next_ef = ef;
		next_il = il;
		next_sel = sel;
		next_sys = sys;
		next_stack = stack;
		next_cause = cause;
		next_div = div + 16'h1;
		// Software writes in the data phase
		if (wr_pend) begin
			case (wr_addr)
				ric_pkg::CTRL_OFS: next_ctrl = hwdata[5:0];
				ric_pkg::ENABLE_OFS: next_ef = hwdata[15:0] & ric_pkg::ENABLE_MASK;
				ric_pkg::LATCH_OFS: next_il = il & hwdata[15:0]; // Zero clears
				ric_pkg::SELECT_OFS: next_sel = hwdata[2:0];
				ric_pkg::SYSCTL_OFS: next_sys = wsys;
				default: ;
			endcase
		end
		// Return restores the stacked master enable
		if (irq_return) begin
			next_ctrl[ric_pkg::CTRL_IMF] = stack[0];
			next_stack = {1'b0, stack[STACK_W-1:1]};
		end
		// Acceptance pushes and clears master enable, clears latch
		if (irq_ack && irq.req) begin
			next_stack = {stack[STACK_W-2:0], ctrl[ric_pkg::CTRL_IMF]};
			next_ctrl[ric_pkg::CTRL_IMF] = 1'b0;
			if (irq.id >= ric_pkg::ID_TRAP)
				next_il[irq.id] = 1'b0;
		end
		// New requests win over software and acceptance clears
		next_il = (next_il | set_il) & ric_pkg::LATCH_MASK;
		if (mal_req)
			next_cause = {clk_rst, wdt_rst, trap_rst, 1'b0};
		if (pin_rst)
			next_cause = 4'h1;
		// Any reset source initialises the control state
		if (core_rst) begin
			next_ctrl = ric_pkg::CTRL_RESET;
			next_ef = 16'h0;
			next_il = 16'h0;
			next_sel = 3'h0;
			next_sys = ric_pkg::SYS_RESET;
			next_stack = '0;
			next_div = 16'h0;
		end
	end

	// Arbitration over the state that becomes current next cycle
	always_comb begin
		req_vec = next_il & next_ef & {16{next_ctrl[ric_pkg::CTRL_IMF]}};
		req_vec[ric_pkg::ID_EXT0] = req_vec[ric_pkg::ID_EXT0]
			& next_ctrl[ric_pkg::CTRL_EXT0_PIN];
		req_vec[ric_pkg::ID_TRAP] = next_il[ric_pkg::ID_TRAP];
		req_vec[ric_pkg::ID_WDT] = next_il[ric_pkg::ID_WDT];
		req_vec[ric_pkg::ID_SOFT] = software_trap_irq | illegal_opcode_irq;
		req_vec[0] = 1'b0;
		if (core_rst)
			req_vec = 16'h0;
		next_irq = '0;
		for (int i = 15; i >= 1; i--) begin
			if (req_vec[i]) begin
				next_irq.req = 1'b1;
				next_irq.id = 4'(i);
				next_irq.vector = ric_pkg::VEC_BASE - {11'h0, 4'(i), 1'b0};
			end
		end
	end

	// Core reset and vector outputs
	assign next_cpu_reset_n = ~core_rst;
	assign next_pc_load = ~cpu_reset_n & ~core_rst;

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	assign addr_phase = hsel & htrans[1] & hready;

	// Address phase capture and read data
	always_comb begin
		next_wr_pend = addr_phase & hwrite;
		next_wr_addr = haddr[7:0];
		next_hrdata = hrdata;
		if (addr_phase && !hwrite) begin
			case (haddr[7:0])
				ric_pkg::CTRL_OFS: next_hrdata = {26'h0, ctrl};
				ric_pkg::ENABLE_OFS: next_hrdata = {16'h0, ef};
				ric_pkg::LATCH_OFS: next_hrdata = {16'h0, il};
				ric_pkg::SELECT_OFS: next_hrdata = {29'h0, sel};
				ric_pkg::SYSCTL_OFS: next_hrdata = {29'h0, sys};
				ric_pkg::STATUS_OFS: next_hrdata = {26'h0, irq.req, core_rst, cause};
				ric_pkg::DIVIDER_OFS: next_hrdata = {16'h0, div};
				default: next_hrdata = 32'h0;
			endcase
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_cnt <= 4'h0;
			mal_cnt <= ric_pkg::MAL_RESET_CYCLES;
			ctrl <= ric_pkg::CTRL_RESET;
			ef <= 16'h0;
			il <= 16'h0;
			sel <= 3'h0;
			sys <= ric_pkg::SYS_RESET;
			cause <= 4'h0;
			div <= 16'h0;
			stack <= '0;
			wr_pend <= 1'b0;
			wr_addr <= 8'h0;
			hrdata <= 32'h0;
			cpu_reset_n <= 1'b0;
			pc_load <= 1'b0;
			reset_vector <= ric_pkg::VEC_BASE;
			irq <= '0;
		end else begin
			pin_cnt <= next_pin_cnt;
			mal_cnt <= next_mal_cnt;
			ctrl <= next_ctrl;
			ef <= next_ef;
			il <= next_il;
			sel <= next_sel;
			sys <= next_sys;
			cause <= next_cause;
			div <= next_div;
			stack <= next_stack;
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
			cpu_reset_n <= next_cpu_reset_n;
			pc_load <= next_pc_load;
			reset_vector <= ric_pkg::VEC_BASE;
			irq <= next_irq;
		end
	end

	assign watchdog_enable = ctrl[ric_pkg::CTRL_WDT_EN];

endmodule : ric_top

// ==== test/ric_top_asserts.sv ====
// Checker of reset and interrupt timing at the controller ports
module ric_asserts (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic rst_pin_n,
	input wire logic fetch_valid,
	input wire logic [15:0] fetch_addr,
	input wire logic watchdog_overflow,
	input wire logic software_trap_irq,
	input wire logic irq_ack,
	input wire logic cpu_reset_n,
	input wire logic pc_load,
	input wire logic watchdog_enable,
	input wire ric_pkg::ric_irq_t irq
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ----------------------------------------
	// Reset and request relations
	// ----------------------------------------
	property p_load; $rose(cpu_reset_n) |-> pc_load && watchdog_enable; endproperty
	a_load: assert property (p_load) else $error("no load at release");
	property p_pin; (!rst_pin_n) [*8] ##1 (!rst_pin_n) [*4] |-> ##[1:3] !cpu_reset_n; endproperty
	a_pin: assert property (p_pin) else $error("pin reset missing");
	property p_mal; $fell(cpu_reset_n) && rst_pin_n |-> ##[1:24] cpu_reset_n; endproperty
	a_mal: assert property (p_mal) else $error("internal reset too long");
	property p_trap; fetch_valid && fetch_addr <= 16'h003f && cpu_reset_n
		|-> ##[1:3] (!cpu_reset_n || irq.req); endproperty
	a_trap: assert property (p_trap) else $error("fetch trap ignored");
	property p_wdt; watchdog_overflow && cpu_reset_n |-> ##[1:3] (!cpu_reset_n || irq.req); endproperty
	a_wdt: assert property (p_wdt) else $error("overflow ignored");
	property p_soft; software_trap_irq && cpu_reset_n |=> irq.req && irq.id == 4'h1; endproperty
	a_soft: assert property (p_soft) else $error("soft request lost");
	property p_ack; irq_ack && irq.req && irq.id > 4'h3 |=> !irq.req || irq.id < 4'h4; endproperty
	a_ack: assert property (p_ack) else $error("maskable after accept");
	property p_map; irq.req |-> irq.vector == 16'hfffe - {11'h0, irq.id, 1'b0}; endproperty
	a_map: assert property (p_map) else $error("bad vector");
	c_ack: cover property (irq_ack && irq.req);
	c_mal: cover property ($fell(cpu_reset_n) && rst_pin_n);
	c_soft: cover property (software_trap_irq && irq_ack);
endmodule : ric_asserts
bind ric_top ric_asserts u_ric_asserts (
	.hclk(hclk),
	.hresetn(hresetn),
	.rst_pin_n(rst_pin_n),
	.fetch_valid(fetch_valid),
	.fetch_addr(fetch_addr),
	.watchdog_overflow(watchdog_overflow),
	.software_trap_irq(software_trap_irq),
	.irq_ack(irq_ack),
	.cpu_reset_n(cpu_reset_n),
	.pc_load(pc_load),
	.watchdog_enable(watchdog_enable),
	.irq(irq)
);

// ==== test/ric_cpu_model.sv ====
// Core model that accepts presented requests after a set wait
module ric_cpu_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire ric_pkg::ric_irq_t irq,
	input wire logic auto_ack,
	input wire logic [3:0] dly,
	output logic irq_ack,
	output logic irq_return,
	output logic [3:0] taken_id
);
	logic [3:0] wait_cnt;
	// Ack only while a request stands; return one cycle later
	// No ack in the return cycle: irq may still show the request just taken
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_cnt <= 4'h0;
			irq_ack <= 1'b0;
			irq_return <= 1'b0;
			taken_id <= 4'h0;
		end else begin
			irq_ack <= 1'b0;
			irq_return <= irq_ack;
			wait_cnt <= 4'h0;
			if (auto_ack && irq.req && !irq_ack && !irq_return) begin
				wait_cnt <= wait_cnt + 4'h1;
				if (wait_cnt >= dly) begin
					irq_ack <= 1'b1;
					taken_id <= irq.id;
				end
			end
		end
	end
endmodule : ric_cpu_model

// ==== test/tb_reset_and_interrupt_control.sv ====
// Self-checking bench for the reset and interrupt controller
module tb_reset_and_interrupt_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, rst_pin_n = 1'b1;
	logic fetch_valid = 1'b0, watchdog_overflow = 1'b0, auto_ack = 1'b1;
	logic software_trap_irq = 1'b0, illegal_opcode_irq = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, r;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [15:0] fetch_addr = 16'h0, reset_vector;
	logic [3:0] dly = 4'h0, taken_id;
	logic hreadyout, hresp, irq_ack, irq_return, cpu_reset_n, pc_load, watchdog_enable;
	wire logic hready;
	ric_pkg::ric_src_t sources = 15'h0;
	ric_pkg::ric_irq_t irq;
	logic [3:0] idt [15] = '{4'hf, 4'hf, 4'he, 4'he, 4'hd, 4'hc, 4'hb, 4'ha, 4'h9, 4'h9, 4'h8,
		4'h7, 4'h6, 4'h5, 4'h4};
	logic [6:0] ck [4] = '{7'h70, 7'h50, 7'h7b, 7'h32};
	int n_fail = 0, check_count = 0, seed = 53567, len, i, b;
	assign hready = hreadyout;
	ric_top u_ric_top (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.rst_pin_n(rst_pin_n),
		.fetch_valid(fetch_valid),
		.fetch_addr(fetch_addr),
		.watchdog_overflow(watchdog_overflow),
		.software_trap_irq(software_trap_irq),
		.illegal_opcode_irq(illegal_opcode_irq),
		.sources(sources),
		.irq_ack(irq_ack),
		.irq_return(irq_return),
		.cpu_reset_n(cpu_reset_n),
		.pc_load(pc_load),
		.reset_vector(reset_vector),
		.watchdog_enable(watchdog_enable),
		.irq(irq)
	);
	ric_cpu_model u_ric_cpu_model (
		.hclk(hclk),
		.hresetn(hresetn),
		.irq(irq),
		.auto_ack(auto_ack),
		.dly(dly),
		.irq_ack(irq_ack),
		.irq_return(irq_return),
		.taken_id(taken_id)
	);
	initial begin
		forever #10 hclk = ~hclk;
	end
	// ----------------------------------------
	// Bus, wait and compare helpers
	// ----------------------------------------
	task automatic report_and_stop();
		$display("checks %0d failures %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic hang();
		n_fail++;
		report_and_stop();
	endtask : hang
	task automatic step();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 99);
		if (hready !== 1'b1) begin
			hang();
		end
	endtask : step
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		step();
		htrans <= 2'h0;
		hwdata <= d;
		step();
		q = hrdata;
	endtask : bus
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rdc
	// Wait for the core to accept, then compare the taken level
	task automatic acc(input logic [3:0] e);
		int n;
		n = 0;
		do begin
			@(negedge hclk);
			n++;
		end while (irq_ack !== 1'b1 && n < 60);
		if (irq_ack !== 1'b1) begin
			hang();
		end
		chk(taken_id, e);
		@(posedge hclk);
	endtask : acc
	// Length of the next internal reset, zero if none comes
	task automatic rst_len();
		int n;
		len = 0;
		for (n = 0; n < 30 && cpu_reset_n === 1'b1; n++) begin
			@(negedge hclk);
		end
		while (cpu_reset_n !== 1'b1 && len < 60) begin
			@(negedge hclk);
			len++;
		end
		if (len == 60) begin
			hang();
		end
		@(posedge hclk);
	endtask : rst_len
	function automatic logic takes(input int b, input logic [3:0] s);
		case (b)
			14: return s[3];
			9: return !s[0];
			8: return s[0];
			3: return !s[1];
			2: return s[1];
			1: return !s[2];
			0: return s[2];
			default: return 1'b1;
		endcase
	endfunction : takes
	// Main sequence
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		rst_len();
		bus(1'b0, ric_pkg::DIVIDER_OFS, 32'h0);
		chk(q < 32'h8, 32'h1);
		chk({16'h0, reset_vector}, 32'hfffe);
		chk({31'h0, hresp}, 32'h0);
		rdc(ric_pkg::CTRL_OFS, 32'h26);
		rdc(ric_pkg::LATCH_OFS, 32'h0);
		rdc(ric_pkg::SYSCTL_OFS, 32'h2);
		rdc(8'h1c, 32'h0);
		bus(1'b1, ric_pkg::ENABLE_OFS, 32'hffffffff);
		rdc(ric_pkg::ENABLE_OFS, 32'hfff0);
		// Masked request waits in its latch
		bus(1'b1, ric_pkg::CTRL_OFS, 32'h20);
		sources <= 15'h0400;
		@(posedge hclk);
		sources <= 15'h0;
		rdc(ric_pkg::LATCH_OFS, 32'h100);
		bus(1'b1, ric_pkg::CTRL_OFS, 32'h21);
		acc(4'h8);
		rdc(ric_pkg::LATCH_OFS, 32'h0);
		// Simultaneous requests, order and master enable restore on return
		auto_ack <= 1'b0;
		bus(1'b1, ric_pkg::CTRL_OFS, 32'h20);
		sources <= 15'h0410;
		watchdog_overflow <= 1'b1;
		@(posedge hclk);
		sources <= 15'h0;
		watchdog_overflow <= 1'b0;
		@(negedge hclk);
		chk(irq.id, 4'h3);
		auto_ack <= 1'b1;
		acc(4'h3);
		bus(1'b1, ric_pkg::CTRL_OFS, 32'h21);
		acc(4'h8);
		acc(4'hd);
		for (i = 0; i < 2; i++) begin
			{software_trap_irq, illegal_opcode_irq} <= 2'h1 << i;
			acc(4'h1);
			{software_trap_irq, illegal_opcode_irq} <= 2'h0;
			@(posedge hclk);
		end
		r = $random(seed);
		fetch_addr <= r[15:0] & 16'h003f;
		fetch_valid <= 1'b1;
		@(posedge hclk);
		fetch_valid <= 1'b0;
		acc(4'h2);
		// Random sources, selects and pin enable
		for (i = 0; i < 30; i++) begin
			r = $random(seed);
			b = r[7:4] % 15;
			dly <= r[11:8];
			bus(1'b1, ric_pkg::SELECT_OFS, {29'h0, r[2:0]});
			bus(1'b1, ric_pkg::CTRL_OFS, {26'h0, 1'b1, r[3], 4'h1});
			sources <= 15'h1 << b;
			@(posedge hclk);
			sources <= 15'h0;
			if (takes(b, r[3:0])) begin
				acc(idt[b]);
			end else begin
				repeat (8) @(posedge hclk);
				chk(irq.req, 1'b0);
			end
			bus(1'b1, ric_pkg::LATCH_OFS, 32'h0);
		end
		// Trap, overflow and oscillator stop resets
		bus(1'b1, ric_pkg::CTRL_OFS, 32'h2e);
		fetch_addr <= 16'h0040 + {5'h0, r[26:16]};
		fetch_valid <= 1'b1;
		@(posedge hclk);
		fetch_valid <= 1'b0;
		rst_len();
		chk(len >= 1 && len <= 24, 32'h1);
		rdc(ric_pkg::CTRL_OFS, 32'h26);
		rdc(ric_pkg::ENABLE_OFS, 32'h0);
		rdc(ric_pkg::STATUS_OFS, 32'h2);
		watchdog_overflow <= 1'b1;
		@(posedge hclk);
		watchdog_overflow <= 1'b0;
		rst_len();
		chk(len >= 1 && len <= 24, 32'h1);
		rdc(ric_pkg::STATUS_OFS, 32'h4);
		for (i = 0; i < 4; i++) begin
			bus(1'b1, ric_pkg::SYSCTL_OFS, {29'h0, ck[i][5:3]});
			bus(1'b1, ric_pkg::SYSCTL_OFS, {29'h0, ck[i][2:0]});
			rst_len();
			chk(len >= 1 && len <= 24, {31'h0, ck[i][6]});
		end
		// Pin held one cycle short, then long enough
		rst_pin_n <= 1'b0;
		repeat (11) @(posedge hclk);
		rst_pin_n <= 1'b1;
		rst_len();
		chk(len, 32'h0);
		rst_pin_n <= 1'b0;
		repeat (14) @(posedge hclk);
		rst_pin_n <= 1'b1;
		rst_len();
		chk(len != 0, 32'h1);
		report_and_stop();
	end
endmodule : tb_reset_and_interrupt_control
